// >>> logic/octal_switch_pkg.sv
/*
 * Constants, field layouts and carriers for the octal load switch
 * serial command and fault logic.
 * Assumes: one system clock domain plus the serial link clock domain.
 */
`default_nettype none

package octal_switch_pkg;

    // ************************************************************
    // Word layout
    // ************************************************************
    localparam int CH_N   = 8;
    localparam int WORD_W = 16;

    // Status high byte always reads zero
    localparam logic [7:0] STATUS_HIGH = 8'h00;

    // Power-on state: all channels off, detection current off
    localparam logic [15:0] CMD_RESET = 16'h0000;

    localparam logic [7:0] CH_NONE = 8'h00;

    // ************************************************************
    // Frame length check: 16 pulses plus any multiple of 8
    // ************************************************************
    localparam logic [4:0] BITS_FIRST = 5'h01;
    localparam logic [4:0] BITS_STEP  = 5'h01;
    localparam logic [4:0] BITS_MIN   = 5'h10;
    localparam logic [4:0] BITS_WRAP  = 5'h17;

    // Rising edges that carry the zero high byte
    localparam logic [3:0] RISE_ZERO = 4'h8;
    localparam logic [3:0] RISE_STEP = 4'h1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] detect_en;
        logic [7:0] on;
    } command_s;

    typedef struct packed {
        logic       cs_n;
        logic       en;
        logic       vdd_ok;
        logic       ov;
        logic [7:0] ot;
        logic [7:0] sc;
        logic [7:0] ol;
    } pins_s;

    localparam pins_s PIN_IDLE = '{cs_n: 1'b1, default: '0};

endpackage

`default_nettype wire

// >>> logic/octal_switch_spi_command_fault.sv
/*
 * Serial command and fault status logic of an eight channel load switch.
 * Assumes: sclk_i idles low and is low at every chip select edge; analog
 * fault inputs are levels; the host waits at least 400 ns after chip
 * select falls before the first clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module octal_switch_spi_command_fault
    import octal_switch_pkg::*;
#(
    parameter int CHANNELS = CH_N
)
(
    // System clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Serial link
    input  wire logic             sclk_i,
    input  wire logic             cs_n_i,
    input  wire logic             sdi_i,
    output logic                  sdo_o,
    output logic                  sdo_oe_n_o,
    // Power and enable pins
    input  wire logic             en_i,
    input  wire logic             vdd_ok_i,
    // Analog fault indications
    input  wire logic             ov_i,
    input  wire logic [CH_N-1:0]  ot_i,
    input  wire logic [CH_N-1:0]  sc_i,
    input  wire logic [CH_N-1:0]  ol_i,
    // Channel drivers
    output logic      [CH_N-1:0]  channel_drive_o,
    output logic      [CH_N-1:0]  detect_current_o
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (CHANNELS != CH_N)
    begin : g_bad_channels
        $error("Channel count must match the command word layout");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    pins_s               pin_raw;
    pins_s               sync1_reg;
    pins_s               sync2_reg;
    pins_s               sync3_reg;
    pins_s               stb_reg;
    logic                cs_prev_reg;
    logic                cs_rise;
    logic                cs_fall;
    logic                sleep;
    logic                commit;
    logic                seen_tog_reg;
    command_s            cmd_reg;
    logic [CH_N-1:0]     fault_now;
    logic [CH_N-1:0]     fault_lat_reg;
    logic [CH_N-1:0]     snap_reg;
    logic [CH_N-1:0]     drive_reg;
    logic [CH_N-1:0]     detect_reg;
    logic [WORD_W-1:0]   status_word;
    logic [WORD_W-1:0]   shift_reg;
    logic [4:0]          bit_cnt_reg;
    logic                frame_tog_reg;
    logic                nfirst_reg;
    logic [3:0]          rise_cnt_reg;
    logic                sdo_reg;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    assign pin_raw = {cs_n_i, en_i, vdd_ok_i, ov_i, ot_i, sc_i, ol_i};

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sync1_reg <= PIN_IDLE;
            sync2_reg <= PIN_IDLE;
            sync3_reg <= PIN_IDLE;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            stb_reg <= PIN_IDLE;
        else
            stb_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg))
                     | (stb_reg & (sync2_reg ^ sync3_reg));
    end

    // ************************************************************
    // Frame edges and sleep
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cs_prev_reg <= 1'b1;
        else
            cs_prev_reg <= stb_reg.cs_n;
    end

    assign cs_rise = stb_reg.cs_n & ~cs_prev_reg;
    assign cs_fall = ~stb_reg.cs_n & cs_prev_reg;

    assign sleep = ~stb_reg.en | ~stb_reg.vdd_ok;

    // Link registers are still once chip select is high
    assign commit = cs_rise & (frame_tog_reg != seen_tog_reg)
                  & (bit_cnt_reg == BITS_MIN);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            seen_tog_reg <= 1'b0;
        else if (cs_rise)
            seen_tog_reg <= frame_tog_reg;
    end

    // ************************************************************
    // Command register
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || sleep)
            cmd_reg <= CMD_RESET;
        else if (commit)
            cmd_reg <= shift_reg;
    end

    // ************************************************************
    // Fault detection
    // ************************************************************
    for (genvar i = 0; i < CH_N; i++)
    begin : g_fault
        assign fault_now[i] = stb_reg.ot[i] | stb_reg.sc[i]
                            | (stb_reg.ol[i] & ~cmd_reg.on[i]
                               & cmd_reg.detect_en[i]);
    end

    // Sticky until a new frame starts; a new fault wins the clear
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || sleep)
            fault_lat_reg <= CH_NONE;
        else
            fault_lat_reg <= (cs_fall ? CH_NONE : fault_lat_reg) | fault_now;
    end

    // Frozen while a frame runs, read by the link side
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            snap_reg <= CH_NONE;
        else if (stb_reg.cs_n)
            snap_reg <= fault_lat_reg | fault_now;
    end

    // ************************************************************
    // Channel drivers
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || sleep || stb_reg.ov)
            drive_reg <= CH_NONE;
        else
            drive_reg <= cmd_reg.on & ~stb_reg.ot;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || sleep)
            detect_reg <= CH_NONE;
        else
            detect_reg <= cmd_reg.detect_en;
    end

    assign channel_drive_o  = drive_reg;
    assign detect_current_o = detect_reg;

    // ************************************************************
    // Link side shifter
    // ************************************************************
    assign status_word = {STATUS_HIGH, snap_reg};

    always_ff @(negedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
            nfirst_reg <= 1'b1;
        else
            nfirst_reg <= 1'b0;
    end

    // Sample on the falling edge, status loaded at the first one
    always_ff @(negedge sclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            shift_reg     <= CMD_RESET;
            bit_cnt_reg   <= 5'h00;
            frame_tog_reg <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            if (nfirst_reg)
            begin
                shift_reg     <= {status_word[WORD_W-2:0], sdi_i};
                bit_cnt_reg   <= BITS_FIRST;
                frame_tog_reg <= ~frame_tog_reg;
            end
            else
            begin
                shift_reg   <= {shift_reg[WORD_W-2:0], sdi_i};
                bit_cnt_reg <= (bit_cnt_reg == BITS_WRAP) ? BITS_MIN
                             : 5'(bit_cnt_reg + BITS_STEP);
            end
        end
    end

    // Output changes on the rising edge
    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            sdo_reg      <= 1'b0;
            rise_cnt_reg <= 4'h0;
        end
        else
        begin
            sdo_reg <= (rise_cnt_reg == 4'h0) ? status_word[WORD_W-1]
                     : shift_reg[WORD_W-1];
            if (rise_cnt_reg != RISE_ZERO)
                rise_cnt_reg <= 4'(rise_cnt_reg + RISE_STEP);
        end
    end

    assign sdo_o      = sdo_reg;
    assign sdo_oe_n_o = cs_n_i;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_commit_ok;
        cs_rise && commit;
    endsequence

    sequence s_cmd_loaded;
        cmd_reg == $past(shift_reg);
    endsequence

    a_commit_loads: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        s_commit_ok and !sleep |=> s_cmd_loaded)
        else $error("Accepted frame not loaded into command");

    a_cmd_holds: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (!commit && !sleep) |=> $stable(cmd_reg))
        else $error("Command changed outside chip select rise");

    a_count_reject: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (cs_rise && bit_cnt_reg != BITS_MIN && !sleep) |=> $stable(cmd_reg))
        else $error("Frame of wrong length was accepted");

    a_sleep_clears: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        sleep |=> (cmd_reg == CMD_RESET) ##1 (detect_current_o == CH_NONE))
        else $error("Sleep did not clear the command");

    a_sleep_entry: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (!stb_reg.en || !stb_reg.vdd_ok) |=> channel_drive_o == CH_NONE)
        else $error("Channels stay on in sleep");

    a_ot_isolated: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (!sleep && !stb_reg.ov) |=>
            channel_drive_o == ($past(cmd_reg.on) & ~$past(stb_reg.ot)))
        else $error("Overtemperature affected the wrong channels");

    a_ov_all_off: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        stb_reg.ov |=> channel_drive_o == CH_NONE)
        else $error("Overvoltage left a channel on");

    a_ol_masked: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (fault_lat_reg == CH_NONE && stb_reg.ot == CH_NONE
         && stb_reg.sc == CH_NONE
         && (stb_reg.ol & cmd_reg.detect_en) == CH_NONE)
        |=> fault_lat_reg == CH_NONE)
        else $error("Open load reported with detection current off");

    a_status_high: assert property (
        @(posedge sclk_i) disable iff (cs_n_i)
        (rise_cnt_reg < RISE_ZERO) |=> !sdo_reg)
        else $error("Status high byte not zero");

endmodule

`default_nettype wire

// >>> tb/spi_host_model.sv
/*
 * Host model: bus master of the serial link, clock idles low.
 * Assumes: device samples on falling and drives on rising clock edges.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_host_model
(
    // Serial link
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        sdi_o  = 1'b0;
        // Deselect edge clears the link stage before the first frame
        #1;
        cs_n_o = 1'b1;
    end

    // ************************************************************
    // One frame of n pulses, MSB first, then the frame gap
    // ************************************************************
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx     = '0;
        cs_n_o = 1'b0;
        #500;
        for (int k = n - 1; k >= 0; k--)
        begin
            sclk_o = 1'b1;
            sdi_o  = tx[k];
            #32;
            sclk_o = 1'b0;
            rx[k]  = sdo_i;
            #32;
        end
        #200;
        cs_n_o = 1'b1;
        sdi_o  = ~sdi_o;
        #301000;
    endtask

    // Clocking while deselected
    task automatic noise();
        repeat (16)
        begin
            sdi_o  = 1'($urandom);
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
            #32;
        end
    endtask

    // Control lines low ahead of supply removal
    task automatic quiet();
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
        cs_n_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the octal switch serial command and fault logic.
 * Assumes: spi_host_model drives the link; faults are stable levels.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
    import octal_switch_pkg::*;

    logic            clk_i;
    logic            sys_rst_i;
    logic            en_i;
    logic            vdd_ok_i;
    logic            ov_i;
    logic [CH_N-1:0] ot_i;
    logic [CH_N-1:0] sc_i;
    logic [CH_N-1:0] ol_i;
    wire logic       sclk;
    wire logic       cs_n;
    wire logic       sdi;
    wire logic       sdo;
    wire logic       sdo_oe_n;
    // Undriven line reads inverted
    wire logic       miso = sdo_oe_n ? ~sdo : sdo;
    wire logic [7:0] drive;
    wire logic [7:0] detect;
    int              err_count;
    int              cmp_count;
    int              dummy;
    int              lens[8] = '{0, 8, 15, 17, 23, 24, 31, 32};
    logic [15:0]     cmd;
    logic [7:0]      seen;
    logic [31:0]     rx;
    logic [15:0]     cls;

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    octal_switch_spi_command_fault i_octal_switch_spi_command_fault (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .en_i(en_i),
        .vdd_ok_i(vdd_ok_i), .ov_i(ov_i), .ot_i(ot_i), .sc_i(sc_i), .ol_i(ol_i),
        .channel_drive_o(drive), .detect_current_o(detect));

    spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(miso));

    // ************************************************************
    // Reference model and checks
    // ************************************************************
    function automatic logic [7:0] fv();
        return ot_i | sc_i | (ol_i & ~cmd[7:0] & cmd[15:8]);
    endfunction

    task automatic chk_status(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("CHECK FAILED t=%0t status %h exp %h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("CHECK FAILED t=%0t outputs %h exp %h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask

    task automatic chk_drive();
        logic [7:0] d;
        d = cmd[7:0] & ~ot_i & {8{~ov_i}};
        chk_out({detect, drive}, {cmd[15:8], d});
    endtask

    task automatic pins(input logic [7:0] t, s, o, input logic v, e, d);
        @(negedge clk_i);
        ot_i     = t;
        sc_i     = s;
        ol_i     = o;
        ov_i     = v;
        en_i     = e;
        vdd_ok_i = d;
        seen    |= fv();
        repeat (10) @(negedge clk_i);
    endtask

    task automatic frame(input int n, input logic [31:0] t);
        logic [15:0] exp;
        logic [31:0] m;
        exp  = {STATUS_HIGH, seen | fv()};
        seen = fv();
        i_spi_host_model.xfer(n, t, rx);
        m = (32'h1 << (n - 16)) - 32'h1;
        if (n >= 16)
            chk_status(rx[n-1 -: 16], exp);
        if (n > 16)
            chk_status(16'(rx & m), 16'((t >> 16) & m));
        if (n >= 16 && n % 8 == 0)
            cmd = t[15:0];
        seen |= fv();
        chk_drive();
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        #8000000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        {sys_rst_i, en_i, vdd_ok_i, ov_i} = 4'b0110;
        {ot_i, sc_i, ol_i} = '0;
        {err_count, cmp_count} = '0;
        cmd   = CMD_RESET;
        seen  = CH_NONE;
        dummy = $urandom(32'h7d56b957);
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        chk_drive();
        repeat (4) frame(16, $urandom);
        $display("test commands done");
        repeat (4)
        begin
            pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b1);
            frame(16, $urandom);
            pins(8'($urandom) & cmd[7:0], 8'($urandom), 8'($urandom), 1'b0, 1'b1, 1'b1);
            chk_drive();
            frame(16, {16'h0000, cmd});
            cls = {8'h00, ~cmd[7:0]};
            chk_status(rx[15:0] & cls, {8'h00, ol_i & cmd[15:8] | sc_i} & cls);
            chk_status(rx[15:0] & ~cls, {8'h00, ot_i | sc_i} & ~cls);
        end
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b1);
        $display("test faults done");
        foreach (lens[i]) frame(lens[i], $urandom);
        $display("test lengths done");
        i_spi_host_model.noise();
        repeat (10) @(negedge clk_i);
        chk_status({14'h0000, sdo_oe_n, sdo}, 16'h0002);
        chk_drive();
        $display("test deselect done");
        frame(16, 32'h0000_00ff);
        pins(8'h04, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b1);
        chk_drive();
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b1, 1'b1, 1'b1);
        chk_drive();
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b1);
        chk_drive();
        $display("test shutdown done");
        frame(16, 32'h0000_ff00);
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b0, 1'b1);
        cmd = CMD_RESET;
        chk_drive();
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b1);
        chk_drive();
        frame(16, $urandom);
        i_spi_host_model.quiet();
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b0);
        cmd = CMD_RESET;
        chk_drive();
        pins(CH_NONE, CH_NONE, CH_NONE, 1'b0, 1'b1, 1'b1);
        chk_drive();
        $display("test sleep done");
        end_of_test();
    end
endmodule

`default_nettype wire
